// file: rtl/pmas_seq.sv
// Converter sequencer with averaging, start delay, threshold compare and alert pin
module pmas_seq import pmas_pkg::*; #(
    parameter int US_CYC = CLK_MHZ
) (
    // Clock, reset, enable
    input  wire logic                clk_sys,
    input  wire logic                nrst,
    input  wire logic                ce,
    // Converter setup write
    input  wire logic                setup_wr,
    input  wire logic [MODE_W-1:0]   mode_field,
    input  wire logic [2:0]          shunt_ct_sel,
    input  wire logic [2:0]          rail_ct_sel,
    input  wire logic [2:0]          temp_ct_sel,
    input  wire logic [2:0]          avg_sel,
    // Start delay write
    input  wire logic                delay_wr,
    input  wire logic [DELAY_W-1:0]  start_delay_field,
    // Alert options
    input  wire logic                fault_latch_en,
    input  wire logic                conversion_done_alert_en,
    input  wire logic                averaged_compare_en,
    input  wire logic                fault_pin_polarity,
    // Threshold write
    input  wire logic                thr_wr,
    input  wire logic [2:0]          thr_sel,
    input  wire logic [DATA_W-1:0]   thr_wdata,
    // Diagnostic read strobe
    input  wire logic                diag_rd,
    // Converter front end and math engine
    input  wire logic [DATA_W-1:0]   adc_data,
    input  wire logic [DATA_W-1:0]   power_value,
    input  wire logic                power_strobe,
    input  wire logic                math_overflow,
    input  wire logic                trim_ok_pin,
    output logic [1:0]               mux_sel,
    output logic                     conv_active,
    output logic                     sample_strobe,
    // Results and status
    output logic [DATA_W-1:0]        shunt_result,
    output logic [DATA_W-1:0]        rail_result,
    output logic [DATA_W-1:0]        temp_result,
    output logic [DATA_W-1:0]        diagnostic_status_reg,
    output logic                     conversion_done_flag,
    // Open-drain alert pin
    output logic                     fault_pin_out,
    output logic                     fault_pin_oe
);
    function automatic logic [2:0] pick_ch(input logic [2:0] en, input int start);
        logic [2:0] r;
        r = 3'h0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (i >= start && en[i]) begin
                r = {1'b1, 2'(i)};
            end
        end
        return r;
    endfunction

    function automatic logic sgt(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
        return $signed(a) > $signed(b);
    endfunction

    // Configuration registers
    logic [MODE_W-1:0]  mode;
    logic [2:0]         ct_sel [NUM_CH];
    logic [2:0]         avg_code;
    logic [DELAY_W-1:0] delay_q;
    logic [DATA_W-1:0]  thr [NUM_THR];

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mode     <= '0;
            ct_sel   <= '{3'h0, 3'h0, 3'h0};
            avg_code <= 3'h0;
            delay_q  <= DELAY_RESET; // [RULE_12]
            thr      <= THR_RESET; // [RULE_16]
        end else if (ce) begin
            if (setup_wr) begin
                mode      <= mode_field;
                ct_sel[0] <= shunt_ct_sel; // [RULE_03]
                ct_sel[1] <= rail_ct_sel;
                ct_sel[2] <= temp_ct_sel;
                avg_code  <= avg_sel; // [RULE_13]
            end
            if (delay_wr) begin
                delay_q <= start_delay_field;
            end
            if (thr_wr && 32'(thr_sel) < NUM_THR) begin
                thr[thr_sel] <= thr_wdata;
            end
        end
    end

    // Trim memory status pin crosses into this domain
    logic trim_s1;
    logic trim_s2;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            trim_s1 <= 1'b0;
            trim_s2 <= 1'b0;
        end else if (ce) begin
            trim_s1 <= trim_ok_pin;
            trim_s2 <= trim_s1;
        end
    end

    // Sequencer
    pmas_state_e       state;
    pmas_state_e       next_state;
    logic [1:0]        ch;
    logic [1:0]        next_ch;
    logic [CNT_W-1:0]  pass_cnt;
    logic [CNT_W-1:0]  next_pass_cnt;
    logic              tmr_load;
    logic [TMR_W-1:0]  tmr_val;
    logic              tmr_done;
    logic              acc_clr;
    logic              acc_add;
    logic              pass_done;
    logic [2:0]        first;
    logic [2:0]        nxt;
    logic [CNT_W-1:0]  avg_n;
    logic              conv_end;

    assign avg_n    = CNT_W'(1) << AVG_SHIFT[avg_code];
    assign first    = pick_ch(mode[2:0], 0);
    assign nxt      = pick_ch(mode[2:0], 32'(ch) + 1);
    assign conv_end = ce && !setup_wr && state == ST_CONV && tmr_done;

    always_comb begin
        next_state    = state;
        next_ch       = ch;
        next_pass_cnt = pass_cnt;
        tmr_load      = 1'b0;
        tmr_val       = '0;
        acc_clr       = 1'b0;
        acc_add       = 1'b0;
        pass_done     = 1'b0;
        if (setup_wr) begin
            // Any mode write throws away partial sums; one that enables an input starts over, else idles
            acc_clr       = 1'b1; // [RULE_09]
            next_pass_cnt = '0;
            if (mode_field[2:0] != 3'h0) begin
                next_state = ST_DELAY;
                tmr_load   = 1'b1;
                tmr_val    = TMR_W'(32'(delay_q) * DELAY_STEP_US * US_CYC); // [RULE_12]
            end else begin
                next_state = ST_IDLE;
            end
        end else begin
            unique case (state)
                ST_IDLE: begin
                end
                ST_DELAY: begin
                    if (tmr_done) begin
                        next_state = ST_CONV;
                        next_ch    = first[1:0]; // [RULE_01]
                        tmr_load   = 1'b1;
                        tmr_val    = TMR_W'(CT_US[ct_sel[first[1:0]]] * US_CYC - 1);
                    end
                end
                ST_CONV: begin
                    if (tmr_done) begin
                        // One period per sample: the filter has settled by its end
                        acc_add = 1'b1; // [RULE_14]
                        if (nxt[2]) begin
                            next_ch  = nxt[1:0]; // [RULE_04]
                            tmr_load = 1'b1;
                            tmr_val  = TMR_W'(CT_US[ct_sel[nxt[1:0]]] * US_CYC - 1); // [RULE_03]
                        end else if (pass_cnt + 1'b1 == avg_n) begin
                            pass_done     = 1'b1; // [RULE_05]
                            acc_clr       = 1'b1;
                            next_pass_cnt = '0;
                            if (mode[MODE_CONT_BIT]) begin
                                next_ch  = first[1:0]; // [RULE_07]
                                tmr_load = 1'b1;
                                tmr_val  = TMR_W'(CT_US[ct_sel[first[1:0]]] * US_CYC - 1);
                            end else begin
                                next_state = ST_IDLE; // [RULE_08]
                            end
                        end else begin
                            next_pass_cnt = pass_cnt + 1'b1; // [RULE_05]
                            next_ch       = first[1:0];
                            tmr_load      = 1'b1;
                            tmr_val       = TMR_W'(CT_US[ct_sel[first[1:0]]] * US_CYC - 1);
                        end
                    end
                end
                default: next_state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state    <= ST_IDLE;
            ch       <= 2'h0;
            pass_cnt <= '0;
        end else if (ce) begin
            state    <= next_state;
            ch       <= next_ch;
            pass_cnt <= next_pass_cnt;
        end
    end

    pmas_timer #(.W(TMR_W)) u_timer (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .ce      (ce),
        .load    (tmr_load && ce),
        .val     (tmr_val),
        .done    (tmr_done)
    );

    // One accumulator per input, all sharing the averaging count
    logic [DATA_W-1:0] avg_val [NUM_CH];
    for (genvar g = 0; g < NUM_CH; g++) begin : g_acc
        pmas_avg #(.W(DATA_W), .AW(DATA_W + 10)) u_avg (
            .clk_sys (clk_sys),
            .nrst    (nrst),
            .ce      (ce),
            .clr     (acc_clr),
            .add     (acc_add && ch == 2'(g)),
            .din     (adc_data),
            .shift   (AVG_SHIFT[avg_code]), // [RULE_13]
            .avg     (avg_val[g])
        );
    end

    assign mux_sel       = ch;
    assign conv_active   = state == ST_CONV;
    assign sample_strobe = conv_end;

    // Results
    logic [DATA_W-1:0] res [NUM_CH];
    logic [DATA_W-1:0] next_res [NUM_CH];
    logic              raw_upd;
    logic              avg_upd;

    assign raw_upd = conv_end && avg_code == 3'h0;
    assign avg_upd = ce && pass_done && avg_code != 3'h0;

    always_comb begin
        next_res = res; // [RULE_06]
        if (raw_upd) begin
            next_res[ch] = adc_data; // [RULE_02]
        end
        for (int i = 0; i < NUM_CH; i++) begin
            if (avg_upd && mode[i]) begin
                next_res[i] = avg_val[i]; // [RULE_05]
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            res <= '{16'h0000, 16'h0000, 16'h0000};
        end else if (ce) begin
            res <= next_res;
        end
    end

    assign shunt_result = res[CH_SHUNT];
    assign rail_result  = res[CH_RAIL];
    assign temp_result  = res[CH_TEMP];

    // Threshold compare and diagnostic flags
    logic [NUM_FLG-1:0] cond;
    logic [NUM_FLG-1:0] next_cond;
    logic [NUM_FLG-1:0] flags;
    logic [NUM_FLG-1:0] next_flags;
    logic               done_q;
    logic               next_done;
    logic               ovf_q;
    logic               next_ovf;
    logic               alert_act;
    logic [DATA_W-1:0]  cv [NUM_CH];
    logic [NUM_CH-1:0]  ce_ch;
    logic               pwr_evt;

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            if (averaged_compare_en) begin
                cv[i]    = avg_val[i]; // [RULE_19]
                ce_ch[i] = ce && pass_done && mode[i];
            end else begin
                cv[i]    = adc_data;
                ce_ch[i] = conv_end && ch == 2'(i);
            end
        end
        pwr_evt   = averaged_compare_en ? (ce && pass_done) : (ce && power_strobe);
        next_cond = cond;
        if (ce_ch[CH_SHUNT]) begin
            next_cond[FLG_SHUNT_LOW]  = sgt(thr[THR_SHUNT_LOW], cv[CH_SHUNT]); // [RULE_15]
            next_cond[FLG_SHUNT_HIGH] = sgt(cv[CH_SHUNT], thr[THR_SHUNT_HIGH]);
        end
        if (ce_ch[CH_RAIL]) begin
            next_cond[FLG_RAIL_LOW]  = sgt(thr[THR_RAIL_LOW], cv[CH_RAIL]);
            next_cond[FLG_RAIL_HIGH] = sgt(cv[CH_RAIL], thr[THR_RAIL_HIGH]);
        end
        if (ce_ch[CH_TEMP]) begin
            next_cond[FLG_OVERHEAT] = sgt(cv[CH_TEMP], thr[THR_OVERHEAT]);
        end
        if (pwr_evt) begin
            next_cond[FLG_OVERPOWER] = power_value > thr[THR_OVERPOWER];
        end
        // Latched flags survive until a read; a fresh hit in the read cycle wins
        if (fault_latch_en) begin
            next_flags = (diag_rd ? '0 : flags) | next_cond; // [RULE_17]
        end else begin
            next_flags = next_cond; // [RULE_23]
        end
        next_done = done_q;
        if (diag_rd || (setup_wr && mode_field[2:0] != 3'h0)) begin
            next_done = 1'b0; // [RULE_11]
        end
        if (pass_done) begin
            next_done = 1'b1; // [RULE_10]
        end
        next_ovf = (ovf_q && !diag_rd) || math_overflow; // [RULE_21]
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cond   <= '0;
            flags  <= '0;
            done_q <= 1'b0;
            ovf_q  <= 1'b0;
        end else if (ce) begin
            cond   <= next_cond;
            flags  <= next_flags;
            done_q <= next_done;
            ovf_q  <= next_ovf;
        end
    end

    // Overflow deliberately left out of the alert sum
    assign alert_act = (|flags) || (conversion_done_alert_en && done_q); // [RULE_18]

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            fault_pin_oe <= 1'b0;
        end else if (ce) begin
            fault_pin_oe <= alert_act ^ fault_pin_polarity; // [RULE_20]
        end
    end

    assign fault_pin_out        = 1'b0;
    assign conversion_done_flag = done_q;

    always_comb begin
        diagnostic_status_reg                  = '0;
        diagnostic_status_reg[NUM_FLG-1:0]     = flags;
        diagnostic_status_reg[DS_ARITH_OVF]    = ovf_q;
        diagnostic_status_reg[DS_TRIM_OK]      = trim_s2; // [RULE_22]
        diagnostic_status_reg[DS_CONV_DONE]    = done_q;
    end

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    property p_abort;
        ce && setup_wr && mode_field[2:0] != 3'h0 |=> state == ST_DELAY && pass_cnt == '0;
    endproperty
    a_abort: assert property (p_abort) else $error("mode write did not restart"); // [RULE_09]

    property p_only_enabled;
        conv_active |-> mode[ch];
    endproperty
    a_only_enabled: assert property (p_only_enabled) else $error("disabled input converted"); // [RULE_01]

    property p_raw;
        raw_upd && ch == CH_SHUNT |=> shunt_result == $past(adc_data);
    endproperty
    a_raw: assert property (p_raw) else $error("raw shunt result not updated"); // [RULE_02]

    property p_hold;
        !raw_upd && !avg_upd |=> $stable(shunt_result) && $stable(temp_result);
    endproperty
    a_hold: assert property (p_hold) else $error("result changed without update"); // [RULE_06]

    property p_done_set;
        ce && pass_done |=> conversion_done_flag;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done flag not set"); // [RULE_10]

    property p_done_clr;
        ce && diag_rd && !pass_done |=> !conversion_done_flag;
    endproperty
    a_done_clr: assert property (p_done_clr) else $error("done flag not cleared"); // [RULE_11]

    property p_single;
        ce && pass_done && !mode[MODE_CONT_BIT] |=> state == ST_IDLE ##1 (setup_wr || state == ST_IDLE);
    endproperty
    a_single: assert property (p_single) else $error("single shot did not stop"); // [RULE_08]

    property p_cont;
        ce && pass_done && mode[MODE_CONT_BIT] |=> state == ST_CONV && ch == first[1:0];
    endproperty
    a_cont: assert property (p_cont) else $error("continuous pass did not repeat"); // [RULE_07]

    property p_latch;
        ce && fault_latch_en && flags != '0 && !diag_rd |=> flags != '0;
    endproperty
    a_latch: assert property (p_latch) else $error("latched flag lost"); // [RULE_17]

    property p_pol;
        ce && alert_act && !fault_pin_polarity |=> fault_pin_oe;
    endproperty
    a_pol: assert property (p_pol) else $error("active-low alert not driven"); // [RULE_20]

    c_cont_pass: cover property (ce && pass_done && mode[MODE_CONT_BIT]);
    c_avg_pass:  cover property (avg_upd);
    c_alert:     cover property (alert_act && fault_latch_en);
endmodule

// file: shared/pmas_pkg.sv
// Constants and types for the power monitor converter sequencer and alert logic
// Notes on behaviour
// RULE_01: Convert only inputs enabled by mode field.
// RULE_02: Without averaging, update each result at conversion end.
// RULE_03: Per-input conversion time, 50 us to 4.12 ms.
// RULE_04: Enabled inputs convert one after another.
// RULE_05: Accumulate samples, load averages after full count.
// RULE_06: Results held until next complete result.
// RULE_07: Continuous mode repeats passes without end.
// RULE_08: Single-shot runs one pass then shuts down.
// RULE_09: Mode write aborts and restarts the sequence.
// RULE_10: Done flag set after full pass completes.
// RULE_11: Done flag cleared by active setup write or read.
// RULE_12: Start delay 0 to 510 ms, 2 ms steps.
// RULE_13: Averaging 1 to 1024, same for all inputs.
// RULE_14: Filter settles within one conversion, no discards.
// RULE_15: Compare results to thresholds, set flags, alert.
// RULE_16: Threshold registers reset to documented defaults.
// RULE_17: Latch holds alert until diagnostic read.
// RULE_18: Done event may drive alert; flag always records.
// RULE_19: Averaged-compare option compares averaged results.
// RULE_20: Alert active low by default, polarity bit inverts.
// RULE_21: Overflow flag set, never drives alert.
// RULE_22: Trim memory status bit reads 1 when healthy.
// RULE_23: Unlatched alert drops when no cause remains.
package pmas_pkg;

    localparam int CLK_MHZ        = 10;
    localparam int TMR_W          = 24;
    localparam int DATA_W         = 16;

    // Mode field: bits 2..0 enable shunt, rail, temperature; bit 3 continuous
    localparam int MODE_W         = 4;
    localparam int MODE_CONT_BIT  = 3;
    localparam int NUM_CH         = 3;
    localparam logic [1:0] CH_SHUNT = 2'h0;
    localparam logic [1:0] CH_RAIL  = 2'h1;
    localparam logic [1:0] CH_TEMP  = 2'h2;

    // Conversion times in microseconds, selected by a 3-bit code
    localparam int CT_US [8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
    // Averaging counts 1,4,16,64,128,256,512,1024 as shifts
    localparam logic [3:0] AVG_SHIFT [8] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha};
    localparam int CNT_W          = 11;

    localparam int DELAY_W        = 8;
    localparam int DELAY_STEP_US  = 2000;
    localparam logic [DELAY_W-1:0] DELAY_RESET = 8'h00;

    // Threshold index and reset values
    localparam int NUM_THR        = 6;
    localparam logic [2:0] THR_SHUNT_LOW  = 3'h0;
    localparam logic [2:0] THR_SHUNT_HIGH = 3'h1;
    localparam logic [2:0] THR_RAIL_HIGH  = 3'h2;
    localparam logic [2:0] THR_RAIL_LOW   = 3'h3;
    localparam logic [2:0] THR_OVERHEAT   = 3'h4;
    localparam logic [2:0] THR_OVERPOWER  = 3'h5;
    localparam logic [DATA_W-1:0] THR_RESET [NUM_THR] =
        '{16'h8000, 16'h7fff, 16'h7fff, 16'h0000, 16'hffff, 16'h7fff};

    // Diagnostic status word layout
    localparam int FLG_OVERPOWER  = 0;
    localparam int FLG_RAIL_LOW   = 1;
    localparam int FLG_RAIL_HIGH  = 2;
    localparam int FLG_SHUNT_LOW  = 3;
    localparam int FLG_SHUNT_HIGH = 4;
    localparam int FLG_OVERHEAT   = 5;
    localparam int NUM_FLG        = 6;
    localparam int DS_ARITH_OVF   = 8;
    localparam int DS_TRIM_OK     = 9;
    localparam int DS_CONV_DONE   = 14;

    typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONV} pmas_state_e;

endpackage

// file: rtl/pmas_timer.sv
// Down-counter that marks the end of a delay or a conversion period
module pmas_timer import pmas_pkg::*; #(
    parameter int W = TMR_W
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    input  wire logic         ce,
    // Control
    input  wire logic         load,
    input  wire logic [W-1:0] val,
    output logic              done
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic         run;
    logic         next_run;

    // Done arrives val+1 enabled cycles after the load
    assign done = ce && run && (cnt == '0);

    always_comb begin
        next_cnt = cnt;
        next_run = run;
        if (load) begin
            next_cnt = val;
            next_run = 1'b1;
        end else if (run) begin
            if (cnt == '0) begin
                next_run = 1'b0;
            end else begin
                next_cnt = cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt <= '0;
            run <= 1'b0;
        end else if (ce) begin
            cnt <= next_cnt;
            run <= next_run;
        end
    end
endmodule

// file: rtl/pmas_avg.sv
// Averaging accumulator for one measured input
module pmas_avg #(
    parameter int W  = 16,
    parameter int AW = 26
) (
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                nrst,
    input  wire logic                ce,
    // Control
    input  wire logic                clr,
    input  wire logic                add,
    input  wire logic signed [W-1:0] din,
    input  wire logic [3:0]          shift,
    output logic signed [W-1:0]      avg
);
    logic signed [AW-1:0] acc;
    logic signed [AW-1:0] sum;
    logic signed [AW-1:0] next_acc;
    logic signed [AW-1:0] quot;

    // Average includes the sample being added, so the last one of a pass counts
    always_comb begin
        sum      = acc + (add ? {{(AW-W){din[W-1]}}, din} : '0);
        quot     = sum >>> shift;
        avg      = quot[W-1:0];
        next_acc = clr ? '0 : sum;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            acc <= '0;
        end else if (ce) begin
            acc <= next_acc;
        end
    end
endmodule

// file: tb/pmas_fe_model.sv
// Behavioural converter front end and power engine facing the sequencer
module pmas_fe_model import pmas_pkg::*; (
    // Sequencer side
    input  wire logic [1:0]        mux_sel,
    input  wire logic              sample_strobe,
    // Analog values seen per input
    input  wire logic [DATA_W-1:0] v_shunt,
    input  wire logic [DATA_W-1:0] v_rail,
    input  wire logic [DATA_W-1:0] v_temp,
    // Results
    output logic [DATA_W-1:0]      adc_data,
    output logic [DATA_W-1:0]      power_value,
    output logic                   power_strobe
);
    logic [DATA_W-1:0] val;
    always_comb begin
        case (mux_sel)
            CH_SHUNT: val = v_shunt;
            CH_RAIL:  val = v_rail;
            default:  val = v_temp;
        endcase
    end
    // Junk outside the sampling cycle so a late capture shows up
    assign adc_data     = sample_strobe ? val : ~val;
    // Power stays at zero, under every power limit
    assign power_value  = '0;
    assign power_strobe = sample_strobe && mux_sel == CH_RAIL;
endmodule

// file: tb/pmas_seq_tb.sv
// Self-checking bench for the converter sequencer and alert pin
module pmas_seq_tb import pmas_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0, nrst = 1'b0, ce = 1'b1;
    logic setup_wr = 1'b0, delay_wr = 1'b0, thr_wr = 1'b0, diag_rd = 1'b0;
    logic math_overflow = 1'b0, trim_ok_pin = 1'b1, fault_latch_en = 1'b0;
    logic conversion_done_alert_en = 1'b0, averaged_compare_en = 1'b0;
    logic fault_pin_polarity = 1'b0;
    logic [MODE_W-1:0] mode_field = '0;
    logic [2:0] shunt_ct_sel = '0, rail_ct_sel = '0, temp_ct_sel = '0;
    logic [2:0] avg_sel = '0, thr_sel = '0;
    logic [DELAY_W-1:0] start_delay_field = '0;
    logic [DATA_W-1:0] thr_wdata = '0, adc_data, power_value;
    logic [DATA_W-1:0] v [3] = '{default: '0};
    logic [DATA_W-1:0] er [3] = '{default: '0};
    logic power_strobe, conv_active, sample_strobe, conversion_done_flag;
    logic fault_pin_out, fault_pin_oe;
    logic [1:0] mux_sel;
    logic [DATA_W-1:0] shunt_result, rail_result, temp_result, diagnostic_status_reg;
    int mismatches = 0, compares = 0, dly = 0, k, i;

    always #50 clk_sys = ~clk_sys;

    pmas_seq #(.US_CYC(1)) pmas_seq_i (.*);
    pmas_fe_model pmas_fe_model_i (.mux_sel(mux_sel), .sample_strobe(sample_strobe),
        .v_shunt(v[0]), .v_rail(v[1]), .v_temp(v[2]), .adc_data(adc_data),
        .power_value(power_value), .power_strobe(power_strobe));

    task automatic test_done();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Busy cycles of a whole measurement for averaging codes 0 and 1, all passes back to back
    function automatic int ctsum(input logic [3:0] m, input logic [2:0] a);
        int s;
        s = (m[0] ? CT_US[shunt_ct_sel] : 0) + (m[1] ? CT_US[rail_ct_sel] : 0);
        s += m[2] ? CT_US[temp_ct_sel] : 0;
        return s * (a == 3'h1 ? 4 : 1);
    endfunction

    task automatic run(input logic [3:0] m);
        int n, cnt, last, pre;
        logic [2:0] seen;
        cnt = 0;
        last = 0;
        pre = 0;
        seen = 3'h0;
        @(posedge clk_sys);
        mode_field <= m;
        setup_wr <= 1'b1;
        @(posedge clk_sys);
        setup_wr <= 1'b0;
        for (n = 0; n < 20000; n++) begin
            cyc(1);
            if (conversion_done_flag === 1'b1) break;
            if (conv_active === 1'b1) cnt++;
            else if (cnt == 0) pre++;
            if (sample_strobe === 1'b1) begin
                last = cnt;
                seen[mux_sel] = 1'b1;
            end
        end
        if (n == 20000) begin
            mismatches++;
            test_done();
        end
        for (i = 0; i < 3; i++) begin
            if (m[i]) er[i] = v[i];
        end
        chk(16'(pre), 16'(dly * 2000));
        chk(16'(last), 16'(ctsum(m, avg_sel)));
        chk(16'(seen), 16'(m[2:0]));
        chk(shunt_result, er[0]);
        chk(rail_result, er[1]);
        chk(temp_result, er[2]);
        $display("pass with mode %h ended", m);
    endtask

    task automatic thr(input logic [2:0] s, input logic [15:0] d);
        @(posedge clk_sys);
        thr_sel <= s;
        thr_wdata <= d;
        thr_wr <= 1'b1;
        @(posedge clk_sys);
        thr_wr <= 1'b0;
    endtask

    initial begin
        void'($urandom(32'hd16d0cf7));
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        cyc(3);
        chk(16'(fault_pin_oe), 16'h0);
        chk(16'(fault_pin_out), 16'h0);
        chk(diagnostic_status_reg, 16'h0200);
        thr(THR_OVERHEAT, 16'h7fff);
        for (k = 0; k < 5; k++) begin
            @(posedge clk_sys);
            shunt_ct_sel <= 3'($urandom_range(2));
            rail_ct_sel <= 3'($urandom_range(2));
            temp_ct_sel <= 3'($urandom_range(2));
            avg_sel <= 3'($urandom_range(1));
            for (i = 0; i < 3; i++) v[i] <= 16'($urandom_range(16'h3fff));
            // Continuous passes are cut short by the next setup write; last one single
            run({1'($urandom_range(1)) & (k < 4), 3'($urandom_range(7, 1))});
        end
        cyc(5);
        chk(16'(conv_active), 16'h0);
        @(posedge clk_sys);
        start_delay_field <= 8'h01;
        delay_wr <= 1'b1;
        @(posedge clk_sys);
        delay_wr <= 1'b0;
        dly = 1;
        run(4'h2);
        thr(THR_SHUNT_HIGH, 16'h0010);
        v[0] <= 16'h0100;
        fault_latch_en <= 1'b1;
        averaged_compare_en <= 1'b1;
        run(4'h1);
        chk(16'(diagnostic_status_reg[FLG_SHUNT_HIGH]), 16'h1);
        // Pin follows the flags one edge later
        cyc(1);
        chk(16'(fault_pin_oe), 16'h1);
        fault_pin_polarity <= 1'b1;
        cyc(2);
        chk(16'(fault_pin_oe), 16'h0);
        fault_pin_polarity <= 1'b0;
        thr(THR_SHUNT_HIGH, 16'h7fff);
        run(4'h1);
        chk(16'(fault_pin_oe), 16'h1);
        conversion_done_alert_en <= 1'b1;
        diag_rd <= 1'b1;
        cyc(1);
        diag_rd <= 1'b0;
        cyc(3);
        chk(16'(conversion_done_flag), 16'h0);
        chk(16'(fault_pin_oe), 16'h0);
        run(4'h1);
        cyc(2);
        chk(16'(fault_pin_oe), 16'h1);
        conversion_done_alert_en <= 1'b0;
        math_overflow <= 1'b1;
        cyc(1);
        math_overflow <= 1'b0;
        cyc(3);
        chk(16'(diagnostic_status_reg[DS_ARITH_OVF]), 16'h1);
        chk(16'(fault_pin_oe), 16'h0);
        $display("alert tests ended");
        test_done();
    end
endmodule
